// ### logic/adc_mode_pkg.sv
// Constants and types for the converter operating-mode controller
package adc_mode_pkg;
    // Register byte offsets
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] RES_OFS = 8'h10;
    localparam logic [7:0] TMR_OFS = 8'h14;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [23:0] TMR_RST = 24'h000000;
    localparam logic [23:0] RES_RST = 24'h000000;
    // Field positions
    localparam int CTRL_SEQ_BIT = 0;
    localparam int CTRL_STP_BIT = 1;
    // State request encodings
    localparam logic [1:0] REQ_CONV = 2'h3;
    localparam logic [1:0] REQ_STBY = 2'h2;
    localparam logic [1:0] REQ_SHDN = 2'h0;
    // Fast command codes
    localparam logic [3:0] FC_CONV = 4'ha;
    localparam logic [3:0] FC_STBY = 4'hb;
    localparam logic [3:0] FC_SHDN = 4'hc;
    localparam logic [3:0] FC_FULL_SD = 4'hd;
    localparam logic [3:0] FC_FULL_RST = 4'he;
    // Counts
    localparam logic [8:0] SETTLE_TICKS = 9'h100;
    localparam logic [1:0] SYNC_CYCLES = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        st_shutdown,
        st_standby,
        st_convert
    } adc_state_t;
endpackage : adc_mode_pkg

// ### logic/mod_tick_gen.sv
// Modulator clock enable divider
`timescale 1ns/1ps
`default_nettype none
module mod_tick_gen #(
    parameter int DIV = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    output logic tick_o
);
    logic [$clog2(DIV)-1:0] div_q;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= '0;
        end else if (clear_i || div_q == ($clog2(DIV))'(DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick_o = !clear_i && div_q == ($clog2(DIV))'(DIV - 1);
endmodule : mod_tick_gen
`default_nettype wire

// ### logic/settle_timer.sv
// Converter settle counter with command synchronisation delay
`timescale 1ns/1ps
`default_nettype none
module settle_timer
    import adc_mode_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic tick_i,
    input wire logic reload_i,
    input wire logic start_i,
    input wire logic sync_i,
    // Status
    output logic [8:0] count_o,
    output logic done_o
);
    logic [8:0] cnt_q;
    logic [1:0] sync_q;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= SETTLE_TICKS;
            sync_q <= 2'h0;
        end else if (start_i && sync_i) begin
            sync_q <= SYNC_CYCLES;
        end else if (reload_i) begin
            cnt_q <= SETTLE_TICKS;
            sync_q <= 2'h0;
        end else if (sync_q != 2'h0) begin
            sync_q <= sync_q - 1'b1;
        end else if (tick_i && cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign count_o = cnt_q;
    assign done_o = cnt_q == 9'h000 && sync_q == 2'h0;
endmodule : settle_timer
`default_nettype wire

// ### logic/adc_mode_ctrl.sv
// Converter operating-mode controller with AHB-Lite register slave
// How it works
// - Decode request: 11 convert, 10 standby, 0x off
// - Fast command per request value, same effect
// - Request field records target, not live state
// - Request field resets to 00, converter off
// - From shutdown, convert after 256 modulator ticks
// - Single channel rewrite restarts conversion, start pulse
// - Sequencer request starts cycle, field reads 11
// - Sequencer rewrite restarts from first entry
// - Restart during powered-down delay waits full settle
// - Result register takes only completed conversions
// - Completion raises data ready on both outputs and the status flag
// - Result kept; cleared by reset or full reset
// - Standby holds converter in reset, powered
// - Shutdown immediate; later conversion waits full settle
// - Full shutdown only via 1101, config cleared
// - Full shutdown disables supply monitoring
// - Bus and registers stay alive in full shutdown
// - Full shutdown resets timers; fast mode command exits
// - Config 0000000x means partial shutdown
// - Entering shutdown reloads settle counter to 256
// - Command wake waits two cycles before counting
// - Standby to convert waits for counter zero
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module adc_mode_ctrl
    import adc_mode_pkg::*;
#(
    parameter int MOD_DIV = 4,
    parameter int CONV_TICKS = 64,
    parameter int SEQ_LEN = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Converter core
    input wire logic [23:0] sample_data_i,
    output logic adc_power_o,
    output logic adc_reset_o,
    output logic conv_start_o,
    output logic [1:0] seq_entry_o,
    // Data ready reporting
    output logic drdy_pulse_o,
    output logic drdy_n_o,
    // Low-power status
    output logic supply_mon_en_o,
    output logic partial_sd_o,
    output logic full_sd_o
);
    logic pend_q;
    logic wr_q;
    logic size_ok_q;
    logic [7:0] addr_q;
    logic [7:0] cfg_q;
    logic [1:0] ctrl_q;
    logic [23:0] tmr_q;
    logic [23:0] result_q;
    logic full_sd_q;
    logic drdy_flag_q;
    adc_state_t state_q;
    adc_state_t state_d;
    logic busy_q;
    logic [$clog2(CONV_TICKS)-1:0] conv_cnt_q;
    logic [1:0] idx_q;
    logic wait_q;
    logic seq_off_q;
    logic [23:0] delay_q;

    logic wr_stb;
    logic rd_stb;
    logic mode_cmd;
    logic [1:0] new_req;
    logic full_sd_cmd;
    logic full_rst;
    logic restart;
    logic tick;
    logic reload;
    logic wake;
    logic [8:0] settle_cnt;
    logic settle_done;
    logic conv_go;
    logic conv_begin;
    logic conv_done;
    logic seq_last;
    logic [31:0] rd_mux;

    // Bus decode: one wait state on every transfer
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            size_ok_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout_o <= 1'b1;
        end else if (hsel_i && htrans_i[1] && hready_i) begin
            pend_q <= 1'b1;
            wr_q <= hwrite_i;
            size_ok_q <= hsize_i == HSIZE_WORD;
            addr_q <= haddr_i[7:0];
            hreadyout_o <= 1'b0;
        end else begin
            pend_q <= 1'b0;
            hreadyout_o <= 1'b1;
        end
    end

    assign wr_stb = pend_q && wr_q && size_ok_q;
    assign rd_stb = pend_q && !wr_q;

    always_comb begin
        rd_mux = 32'h00000000;
        case (addr_q)
            CFG_OFS: rd_mux = {24'h000000, cfg_q};
            CTRL_OFS: rd_mux = {30'h00000000, ctrl_q};
            STAT_OFS: rd_mux = {14'h0000, drdy_flag_q, busy_q, wait_q,
                seq_off_q, partial_sd_o, full_sd_q, settle_cnt,
                settle_done, state_q};
            RES_OFS: rd_mux = {8'h00, result_q};
            TMR_OFS: rd_mux = {8'h00, tmr_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h00000000;
            hresp_o <= 1'b0;
        end else if (rd_stb) begin
            hrdata_o <= rd_mux;
        end
    end

    // Command decode from config writes and fast commands
    always_comb begin
        mode_cmd = 1'b0;
        new_req = REQ_SHDN;
        full_sd_cmd = 1'b0;
        full_rst = 1'b0;
        if (wr_stb && addr_q == CFG_OFS) begin
            mode_cmd = 1'b1;
            new_req = hwdata_i[1:0];
        end else if (wr_stb && addr_q == CMD_OFS) begin
            case (hwdata_i[3:0])
                FC_CONV: begin
                    mode_cmd = 1'b1;
                    new_req = REQ_CONV;
                end
                FC_STBY: begin
                    mode_cmd = 1'b1;
                    new_req = REQ_STBY;
                end
                FC_SHDN: begin
                    mode_cmd = 1'b1;
                    new_req = REQ_SHDN;
                end
                FC_FULL_SD: full_sd_cmd = 1'b1;
                FC_FULL_RST: full_rst = 1'b1;
                default: mode_cmd = 1'b0;
            endcase
        end
    end

    assign restart = mode_cmd && new_req == REQ_CONV
        && cfg_q[1:0] == REQ_CONV;

    // Registers
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q <= CFG_RST;
            ctrl_q <= CTRL_RST;
            tmr_q <= TMR_RST;
        end else if (full_rst) begin
            cfg_q <= CFG_RST;
            ctrl_q <= CTRL_RST;
            tmr_q <= TMR_RST;
        end else if (full_sd_cmd) begin
            cfg_q <= 8'h00;
        end else if (wr_stb && addr_q == CFG_OFS) begin
            cfg_q <= hwdata_i[7:0];
        end else if (mode_cmd) begin
            cfg_q[1:0] <= new_req;
        end else if (wr_stb && addr_q == CTRL_OFS) begin
            ctrl_q <= hwdata_i[1:0];
        end else if (wr_stb && addr_q == TMR_OFS) begin
            tmr_q <= hwdata_i[23:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            full_sd_q <= 1'b0;
        end else if (full_sd_cmd) begin
            full_sd_q <= 1'b1;
        end else if (mode_cmd && addr_q == CMD_OFS || full_rst) begin
            full_sd_q <= 1'b0;
        end
    end

    // Result register and data ready flag
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            result_q <= RES_RST;
        end else if (full_rst) begin
            result_q <= RES_RST;
        end else if (conv_done) begin
            result_q <= sample_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            drdy_flag_q <= 1'b0;
        end else if (conv_done) begin
            drdy_flag_q <= 1'b1;
        end else if (rd_stb && addr_q == RES_OFS || full_rst) begin
            drdy_flag_q <= 1'b0;
        end
    end

    // Live converter state
    always_comb begin
        state_d = st_shutdown;
        if (full_sd_q || full_sd_cmd || full_rst) begin
            state_d = st_shutdown;
        end else if (!cfg_q[1] || seq_off_q) begin
            state_d = st_shutdown;
        end else if (cfg_q[0]) begin
            state_d = st_convert;
        end else begin
            state_d = st_standby;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= st_shutdown;
        end else begin
            state_q <= state_d;
        end
    end

    assign reload = state_d == st_shutdown;
    assign wake = mode_cmd && new_req[1] && state_q == st_shutdown;

    mod_tick_gen #(
        .DIV(MOD_DIV)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(full_sd_q),
        .tick_o(tick)
    );

    settle_timer u_settle (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .reload_i(reload),
        .start_i(wake),
        .sync_i(mode_cmd),
        .count_o(settle_cnt),
        .done_o(settle_done)
    );

    // Conversion engine
    assign conv_go = state_q == st_convert && settle_done
        && !wait_q && !restart;
    assign conv_begin = conv_go && !busy_q;
    assign conv_done = busy_q && conv_go && tick
        && conv_cnt_q == ($clog2(CONV_TICKS))'(CONV_TICKS - 1);
    assign seq_last = idx_q == 2'(SEQ_LEN - 1);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
            conv_cnt_q <= '0;
        end else if (!conv_go || conv_done) begin
            busy_q <= 1'b0;
            conv_cnt_q <= '0;
        end else if (conv_begin) begin
            busy_q <= 1'b1;
            conv_cnt_q <= '0;
        end else if (tick) begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
        end
    end

    // Sequencer: entries, inter-cycle delay, power-down during delay
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            idx_q <= 2'h0;
            wait_q <= 1'b0;
            seq_off_q <= 1'b0;
            delay_q <= 24'h000000;
        end else if (restart || !ctrl_q[CTRL_SEQ_BIT]
                || cfg_q[1:0] != REQ_CONV || full_sd_q) begin
            idx_q <= 2'h0;
            wait_q <= 1'b0;
            seq_off_q <= 1'b0;
            delay_q <= 24'h000000;
        end else if (conv_done && !seq_last) begin
            idx_q <= idx_q + 1'b1;
        end else if (conv_done) begin
            idx_q <= 2'h0;
            wait_q <= tmr_q != 24'h000000;
            seq_off_q <= tmr_q > {15'h0000, SETTLE_TICKS};
            delay_q <= tmr_q;
        end else if (wait_q && tick) begin
            delay_q <= delay_q - 1'b1;
            wait_q <= delay_q != 24'h000001;
            if (delay_q == {15'h0000, SETTLE_TICKS}) begin
                seq_off_q <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            adc_power_o <= 1'b0;
            adc_reset_o <= 1'b1;
            conv_start_o <= 1'b0;
            seq_entry_o <= 2'h0;
            drdy_pulse_o <= 1'b0;
            drdy_n_o <= 1'b1;
            supply_mon_en_o <= 1'b1;
            partial_sd_o <= 1'b0;
            full_sd_o <= 1'b0;
        end else begin
            adc_power_o <= state_q != st_shutdown;
            adc_reset_o <= !busy_q;
            conv_start_o <= conv_begin
                && ctrl_q[CTRL_STP_BIT];
            seq_entry_o <= idx_q;
            drdy_pulse_o <= conv_done;
            drdy_n_o <= !(drdy_flag_q || conv_done);
            supply_mon_en_o <= !full_sd_q;
            partial_sd_o <= cfg_q[7:1] == 7'h00 && !full_sd_q;
            full_sd_o <= full_sd_q;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_full_sd_clear;
        full_sd_cmd |=> cfg_q == 8'h00 && full_sd_q ##1 full_sd_o;
    endproperty
    a_full_sd_clear: assert property (p_full_sd_clear)
        else $error("full shutdown did not clear config");

    property p_shdn_reload;
        state_q == st_shutdown |-> settle_cnt == SETTLE_TICKS;
    endproperty
    a_shdn_reload: assert property (p_shdn_reload)
        else $error("settle counter not reloaded in shutdown");

    property p_sync_delay;
        mode_cmd && new_req[1] && state_q == st_shutdown
            && !full_sd_q && !seq_off_q
            |=> (settle_cnt == SETTLE_TICKS) [*2];
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("settle count moved during sync delay");

    property p_result_source;
        $changed(result_q) |-> $past(conv_done) || $past(full_rst);
    endproperty
    a_result_source: assert property (p_result_source)
        else $error("result changed without completed conversion");

    property p_drdy;
        conv_done |=> drdy_pulse_o && !drdy_n_o && drdy_flag_q;
    endproperty
    a_drdy: assert property (p_drdy)
        else $error("data ready not raised on all outputs");

    property p_monitor_off;
        full_sd_q |=> !supply_mon_en_o && !adc_power_o;
    endproperty
    a_monitor_off: assert property (p_monitor_off)
        else $error("monitoring active in full shutdown");

    property p_conv_after_settle;
        $rose(busy_q) |-> $past(settle_done)
            && $past(state_q) == st_convert;
    endproperty
    a_conv_after_settle: assert property (p_conv_after_settle)
        else $error("conversion began before settle end");

    property p_restart;
        restart && state_q == st_convert && busy_q
            |=> !busy_q && idx_q == 2'h0 ##1 busy_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("rewrite did not restart conversion");

    property p_start_pulse;
        $rose(busy_q) |-> conv_start_o == $past(ctrl_q[CTRL_STP_BIT]);
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse mismatch");

    c_full_sd: cover property (full_sd_cmd ##1 full_sd_q);
    c_restart: cover property (restart && busy_q);
    c_seq_off: cover property (wait_q && seq_off_q ##1 !seq_off_q);
    c_done: cover property (conv_done);
endmodule : adc_mode_ctrl
`default_nettype wire

// ### tb/host_model.sv
// Bus master model of the host processor
`timescale 1ns/1ps
`default_nettype none
module host_model
    import adc_mode_pkg::*;
(
    // Clock and bus answer
    input wire logic ref_clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    // Bus request
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h00000000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = HSIZE_WORD;
        hwdata_o = 32'h00000000;
    end

    // Single word transfer; called just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata);
        hsel_o <= 1'b1;
        haddr_o <= {24'h000000, addr};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hsize_o <= HSIZE_WORD;
        hwdata_o <= ~hwdata_o;
        do begin
            @(posedge ref_clk_i);
        end while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= wdata;
        do begin
            @(posedge ref_clk_i);
        end while (hready_i !== 1'b1);
        rdata = hrdata_i;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb
    import adc_mode_pkg::*;
;
    logic ref_clk_i;
    logic reset_i;
    logic hsel_i;
    logic [31:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic [23:0] sample_data_i;
    logic adc_power_o;
    logic adc_reset_o;
    logic conv_start_o;
    logic drdy_pulse_o;
    logic drdy_n_o;
    logic supply_mon_en_o;
    logic partial_sd_o;
    logic full_sd_o;
    logic hresp_o;
    logic [1:0] seq_entry_o;
    logic [31:0] rd;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int starts = 0;
    int drdys = 0;

    adc_mode_ctrl #(.CONV_TICKS(4)) adc_mode_ctrl_i (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .sample_data_i(sample_data_i), .adc_power_o(adc_power_o),
        .adc_reset_o(adc_reset_o), .conv_start_o(conv_start_o),
        .seq_entry_o(seq_entry_o), .drdy_pulse_o(drdy_pulse_o),
        .drdy_n_o(drdy_n_o), .supply_mon_en_o(supply_mon_en_o),
        .partial_sd_o(partial_sd_o), .full_sd_o(full_sd_o)
    );

    host_model host_model_i (
        .ref_clk_i(ref_clk_i), .hready_i(hreadyout_o),
        .hrdata_i(hrdata_o), .hsel_o(hsel_i), .haddr_o(haddr_i),
        .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i),
        .hwdata_o(hwdata_i)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // Event counters for one-cycle pulses
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (conv_start_o === 1'b1) starts <= starts + 1;
        if (drdy_pulse_o === 1'b1) drdys <= drdys + 1;
    end

    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_model_i.xfer(1'b1, a, d, x);
        repeat (3) @(posedge ref_clk_i);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        host_model_i.xfer(1'b0, a, 32'h00000000, rd);
    endtask : rdr

    // Cycles until the next conversion start, bounded
    task automatic wait_start(input int s0, output int n);
        n = 0;
        while (starts == s0 && n < 3000) begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask : wait_start

    task automatic t_reset();
        rdr(CFG_OFS);
        chk("config", rd, 32'h00000000);
        rdr(STAT_OFS);
        chk("live state", {30'h0, rd[1:0]}, 32'h00000000);
        chk("settle count", {23'h0, rd[11:3]}, 32'h00000100);
        chk("partial", {31'h0, partial_sd_o}, 32'h1);
        chk("power", {31'h0, adc_power_o}, 32'h0);
        rdr(8'h20);
        chk("unmapped", rd, 32'h00000000);
        chk("response", {31'h0, hresp_o}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_wake(input logic [23:0] smp);
        int c;
        int s;
        int n;
        sample_data_i <= smp;
        wr(CTRL_OFS, 32'h00000002);
        c = cyc;
        s = starts;
        wr(CFG_OFS, 32'h00000003);
        wait_start(s, n);
        n = cyc - c;
        chk("settle", {31'h0, n >= 1020 && n <= 1100}, 32'h1);
        chk("partial off", {31'h0, partial_sd_o}, 32'h0);
        s = drdys;
        n = 0;
        while (drdys == s && n < 200) begin
            @(posedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
        chk("drdy level", {31'h0, drdy_n_o}, 32'h0);
        rdr(RES_OFS);
        chk("result", rd, {8'h00, smp});
        rdr(CFG_OFS);
        chk("request", rd, 32'h00000003);
        $display("test wake done");
    endtask : t_wake

    task automatic t_restart();
        int n;
        int s;
        int c;
        wait_start(starts, n);
        s = starts;
        c = cyc;
        wr(CFG_OFS, 32'h00000003);
        wait_start(s, n);
        n = cyc - c;
        chk("restart", {31'h0, n < 8}, 32'h1);
        $display("test restart done");
    endtask : t_restart

    task automatic t_standby();
        int n;
        int s;
        wr(CFG_OFS, 32'h00000002);
        chk("stby reset", {31'h0, adc_reset_o}, 32'h1);
        chk("stby power", {31'h0, adc_power_o}, 32'h1);
        rdr(STAT_OFS);
        chk("stby state", {30'h0, rd[1:0]}, 32'h00000001);
        s = starts;
        wr(CFG_OFS, 32'h00000003);
        wait_start(s, n);
        chk("stby to conv", {31'h0, n < 8}, 32'h1);
        $display("test standby done");
    endtask : t_standby

    task automatic t_seq();
        int s;
        int c;
        int n;
        wr(CTRL_OFS, 32'h00000003);
        wr(CFG_OFS, 32'h00000003);
        s = drdys;
        n = 0;
        while (drdys == s && n < 200) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk("entry one", {30'h0, seq_entry_o}, 32'h00000001);
        @(posedge ref_clk_i);
        s = starts;
        wr(CFG_OFS, 32'h00000003);
        chk("entry zero", {30'h0, seq_entry_o}, 32'h0);
        chk("seq pulse", {31'h0, starts != s}, 32'h1);
        wr(TMR_OFS, 32'h00000200);
        repeat (100) @(posedge ref_clk_i);
        chk("delay power", {31'h0, adc_power_o}, 32'h0);
        rdr(CFG_OFS);
        chk("seq request", rd, 32'h00000003);
        s = starts;
        c = cyc;
        wr(CFG_OFS, 32'h00000003);
        wait_start(s, n);
        n = cyc - c;
        chk("seq settle", {31'h0, n >= 1024}, 32'h1);
        $display("test sequencer done");
    endtask : t_seq

    task automatic t_shutdown();
        wr(CFG_OFS, 32'h00000001);
        chk("off power", {31'h0, adc_power_o}, 32'h0);
        chk("off partial", {31'h0, partial_sd_o}, 32'h1);
        rdr(STAT_OFS);
        chk("off count", {23'h0, rd[11:3]}, 32'h00000100);
        t_wake(24'h0f1e2d);
        $display("test shutdown done");
    endtask : t_shutdown

    task automatic t_fullsd();
        logic [3:0] code [3] = '{FC_CONV, FC_STBY, FC_SHDN};
        logic [31:0] mode [3] = '{32'h3, 32'h2, 32'h0};
        for (int i = 0; i < 3; i++) begin
            wr(CMD_OFS, {28'h0, FC_FULL_SD});
            chk("full sd", {31'h0, full_sd_o}, 32'h1);
            chk("monitor", {31'h0, supply_mon_en_o}, 32'h0);
            rdr(CFG_OFS);
            chk("sd config", rd, 32'h00000000);
            rdr(RES_OFS);
            chk("sd result", rd, 32'h000f1e2d);
            wr(CMD_OFS, {28'h0, code[i]});
            chk("sd exit", {31'h0, full_sd_o}, 32'h0);
            chk("monitor on", {31'h0, supply_mon_en_o}, 32'h1);
            rdr(CFG_OFS);
            chk("fast mode", rd, mode[i]);
        end
        $display("test full shutdown done");
    endtask : t_fullsd

    task automatic t_fullrst();
        wr(CMD_OFS, {28'h0, FC_FULL_RST});
        rdr(RES_OFS);
        chk("cleared result", rd, 32'h00000000);
        $display("test full reset done");
    endtask : t_fullrst

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        final_report();
    end

    initial begin
        reset_i = 1'b1;
        sample_data_i = 24'h000000;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_wake(24'h3c5a96);
        t_restart();
        t_standby();
        t_seq();
        t_shutdown();
        t_fullsd();
        t_fullrst();
        final_report();
    end
endmodule : tb
`default_nettype wire
